/* shared/fts_regs.svh */
`ifndef FTS_REGS_SVH
`define FTS_REGS_SVH

// =====================================================================
// Register offsets
`define FTS_ADDR_CTRL 8'h00
`define FTS_ADDR_TRIP 8'h04
`define FTS_ADDR_STATUS 8'h08
`define FTS_ADDR_COUNT 8'h0C
`define FTS_ADDR_TICKS 8'h10

// =====================================================================
// Field positions and reset values
`define FTS_CTRL_W 18
`define FTS_CTRL_RESET 18'h0_0000
`define FTS_TRIP_W 18
`define FTS_TRIP_RESET 18'h0_2710
`define FTS_TRIP_MIN 18'h0_0001
`define FTS_TRIP_MAX 18'h3_D090
`define FTS_ST_RELAY 0
`define FTS_ST_TRIPREG 1
`define FTS_ST_RELREG 2
`define FTS_ST_OVR 3
`define FTS_ST_ARMED 4

// =====================================================================
// Scales and timing
`define FTS_UNITS_PER_HZ 64'h0000_0000_0000_000A
`define FTS_BP_FULL 14'h2710
`define FTS_WIN_STEPS 4'h9
`define FTS_PCT_STEPS 4'h9
`define FTS_ZERO_MS 32'h0000_2710
`define FTS_BLINK_MS 32'h0000_00FA

`endif

/* shared/fts_pkg.sv */
package fts_pkg;

    typedef enum logic [2:0] {
        FTS_OVER = 3'h0,
        FTS_OVER_LATCH = 3'h1,
        FTS_UNDER = 3'h2,
        FTS_UNDER_LATCH = 3'h3,
        FTS_UNDER_INH = 3'h4,
        FTS_UNDER_INH_LATCH = 3'h5
    } fts_mode_e;

    typedef enum logic [1:0] {
        FTS_IDLE = 2'h0,
        FTS_RUN = 2'h1,
        FTS_WAIT = 2'h3
    } fts_meter_e;

    typedef struct packed {
        logic [1:0] item;
        logic setup;
        logic [3:0] hyst_sel;
        logic [3:0] off_sel;
        logic [3:0] win_sel;
        fts_mode_e mode;
    } fts_cfg_s;

    typedef struct packed {
        logic valid;
        logic [19:0] edges;
        logic [31:0] ticks;
    } fts_meas_s;

endpackage

/* rtl/fts_meter.sv */
`timescale 1ns/100ps

module fts_meter
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Input edges and window lengths in clock cycles
    input wire logic edge_fall,
    input wire logic [31:0] win_cycles,
    input wire logic [31:0] zero_cycles,
    // Result of each window
    output fts_pkg::fts_meas_s meas
);

    fts_pkg::fts_meter_e state;
    fts_pkg::fts_meter_e next_state;
    logic [31:0] tcnt;
    logic [31:0] next_tcnt;
    logic [19:0] ecnt;
    logic [19:0] next_ecnt;
    fts_pkg::fts_meas_s next_meas;

    // =================================================================
    // Window sequencing
    always_comb
    begin
        next_state = state;
        next_tcnt = tcnt + 32'h0000_0001;
        next_ecnt = ecnt;
        next_meas = meas;
        next_meas.valid = 1'b0;
        case (state)
            fts_pkg::FTS_IDLE:
            begin
                if (edge_fall)
                begin
                    next_state = fts_pkg::FTS_RUN;
                    next_tcnt = 32'h0000_0000;
                    next_ecnt = 20'h0_0000;
                end
                else if (tcnt >= zero_cycles)
                begin
                    next_meas = '{1'b1, 20'h0_0000, tcnt};
                    next_tcnt = 32'h0000_0000;
                end
            end
            fts_pkg::FTS_RUN:
            begin
                if (edge_fall)
                    next_ecnt = ecnt + 20'h0_0001;
                if (tcnt + 32'h0000_0001 >= win_cycles)
                    next_state = fts_pkg::FTS_WAIT;
            end
            fts_pkg::FTS_WAIT:
            begin
                if (edge_fall)
                begin
                    next_meas = '{1'b1, ecnt + 20'h0_0001,
                        tcnt + 32'h0000_0001};
                    next_state = fts_pkg::FTS_RUN;
                    next_tcnt = 32'h0000_0000;
                    next_ecnt = 20'h0_0000;
                end
                else if (tcnt >= win_cycles + zero_cycles)
                begin
                    next_meas = '{1'b1, 20'h0_0000, tcnt};
                    next_state = fts_pkg::FTS_IDLE;
                    next_tcnt = 32'h0000_0000;
                end
            end
            default:
            begin
                next_state = fts_pkg::FTS_IDLE;
                next_tcnt = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state <= fts_pkg::FTS_IDLE;
            tcnt <= 32'h0000_0000;
            ecnt <= 20'h0_0000;
            meas <= '0;
        end
        else
        begin
            state <= next_state;
            tcnt <= next_tcnt;
            ecnt <= next_ecnt;
            meas <= next_meas;
        end
    end

endmodule

/* rtl/fts_top.sv */
`timescale 1ns/100ps
`include "fts_regs.svh"

module fts_top
#(
    parameter int CLK_HZ = 25_000_000
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Sensor and control pins
    input wire logic pulse_in,
    input wire logic override_n,
    input wire logic clear_n,
    // Relay and indicators
    output logic relay,
    output logic led_input,
    output logic led_relay
);

    localparam int TPM = CLK_HZ / 1000;

    if (CLK_HZ < 1000 || CLK_HZ > 100_000_000)
    begin : g_chk
        $error("fts_top: CLK_HZ out of range");
    end

    // =================================================================
    // Decoding tables
    function automatic logic [31:0] win_ms(input logic [3:0] sel);
        logic [31:0] v;
        v = 32'h0000_0005;
        case (sel)
            4'h1: v = 32'h0000_000A;
            4'h2: v = 32'h0000_0014;
            4'h3: v = 32'h0000_0032;
            4'h4: v = 32'h0000_0064;
            4'h5: v = 32'h0000_00C8;
            4'h6: v = 32'h0000_01F4;
            4'h7: v = 32'h0000_03E8;
            4'h8: v = 32'h0000_1388;
            4'h9: v = 32'h0000_2710;
            default: v = 32'h0000_0005;
        endcase
        return v;
    endfunction

    function automatic logic [13:0] pct_bp(input logic [3:0] sel);
        logic [13:0] v;
        v = 14'h0000;
        case (sel)
            4'h1: v = 14'h0019;
            4'h2: v = 14'h0032;
            4'h3: v = 14'h0064;
            4'h4: v = 14'h00C8;
            4'h5: v = 14'h012C;
            4'h6: v = 14'h01F4;
            4'h7: v = 14'h03E8;
            4'h8: v = 14'h07D0;
            4'h9: v = 14'h0D05;
            default: v = 14'h0000;
        endcase
        return v;
    endfunction

    // =================================================================
    // Pin synchronisers and edge detection
    logic [2:0] pulse_sync;
    logic [1:0] ovr_sync;
    logic [1:0] clr_sync;
    logic edge_fall;
    logic ovr_act;
    logic clr_act;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            pulse_sync <= 3'h7;
            ovr_sync <= 2'h3;
            clr_sync <= 2'h3;
        end
        else
        begin
            pulse_sync <= {pulse_sync[1:0], pulse_in};
            ovr_sync <= {ovr_sync[0], override_n};
            clr_sync <= {clr_sync[0], clear_n};
        end
    end

    assign edge_fall = pulse_sync[2] & ~pulse_sync[1];
    assign ovr_act = ~ovr_sync[1];
    assign clr_act = ~clr_sync[1];

    // =================================================================
    // Configuration registers
    fts_pkg::fts_cfg_s cfg;
    fts_pkg::fts_cfg_s next_cfg;
    fts_pkg::fts_cfg_s wcfg;
    logic [`FTS_TRIP_W-1:0] trip;
    logic [`FTS_TRIP_W-1:0] next_trip;

    always_comb
    begin
        next_cfg = cfg;
        next_trip = trip;
        wcfg = fts_pkg::fts_cfg_s'(wdata[`FTS_CTRL_W-1:0]);
        if (wr && addr == `FTS_ADDR_CTRL)
        begin
            next_cfg = wcfg;
            if (wcfg.mode > fts_pkg::FTS_UNDER_INH_LATCH)
                next_cfg.mode = fts_pkg::FTS_OVER;
            if (wcfg.win_sel > `FTS_WIN_STEPS)
                next_cfg.win_sel = `FTS_WIN_STEPS;
            if (wcfg.off_sel > `FTS_PCT_STEPS)
                next_cfg.off_sel = `FTS_PCT_STEPS;
            if (wcfg.hyst_sel > `FTS_PCT_STEPS)
                next_cfg.hyst_sel = `FTS_PCT_STEPS;
        end
        else if (wr && addr == `FTS_ADDR_TRIP)
        begin
            next_trip = wdata[`FTS_TRIP_W-1:0];
            if (wdata[31:0] < {14'h0000, `FTS_TRIP_MIN})
                next_trip = `FTS_TRIP_MIN;
            else if (wdata[31:0] > {14'h0000, `FTS_TRIP_MAX})
                next_trip = `FTS_TRIP_MAX;
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            cfg <= fts_pkg::fts_cfg_s'(`FTS_CTRL_RESET);
            trip <= `FTS_TRIP_RESET;
        end
        else
        begin
            cfg <= next_cfg;
            trip <= next_trip;
        end
    end

    // =================================================================
    // Frequency measurement
    fts_pkg::fts_meas_s meas;
    logic [31:0] win_cycles;
    logic [31:0] zero_cycles;

    assign win_cycles = win_ms(cfg.win_sel) * 32'(TPM);
    assign zero_cycles = `FTS_ZERO_MS * 32'(TPM);

    fts_meter u_meter
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .edge_fall(edge_fall),
        .win_cycles(win_cycles),
        .zero_cycles(zero_cycles),
        .meas(meas)
    );

    // =================================================================
    // Trip and release comparison
    logic over;
    logic latching;
    logic inhibit;
    logic [13:0] p_trip;
    logic [13:0] p_rel;
    logic [63:0] lhs;
    logic [63:0] rhs_trip;
    logic [63:0] rhs_rel;
    logic in_trip;
    logic in_rel;

    always_comb
    begin
        over = cfg.mode == fts_pkg::FTS_OVER ||
            cfg.mode == fts_pkg::FTS_OVER_LATCH;
        latching = cfg.mode == fts_pkg::FTS_OVER_LATCH ||
            cfg.mode == fts_pkg::FTS_UNDER_LATCH ||
            cfg.mode == fts_pkg::FTS_UNDER_INH_LATCH;
        inhibit = cfg.mode == fts_pkg::FTS_UNDER_INH ||
            cfg.mode == fts_pkg::FTS_UNDER_INH_LATCH;
        p_trip = over ? `FTS_BP_FULL + pct_bp(cfg.off_sel)
            : `FTS_BP_FULL - pct_bp(cfg.off_sel);
        p_rel = over ? p_trip - pct_bp(cfg.hyst_sel)
            : p_trip + pct_bp(cfg.hyst_sel);
        lhs = {44'h0, meas.edges} * 64'(CLK_HZ) *
            `FTS_UNITS_PER_HZ * {50'h0, `FTS_BP_FULL};
        rhs_trip = {46'h0, trip} * {50'h0, p_trip} * {32'h0, meas.ticks};
        rhs_rel = {46'h0, trip} * {50'h0, p_rel} * {32'h0, meas.ticks};
        in_trip = over ? lhs > rhs_trip : lhs < rhs_trip;
        in_rel = over ? lhs < rhs_rel : lhs > rhs_rel;
    end

    // =================================================================
    // Relay state
    logic tripped;
    logic next_tripped;
    logic trip_reg;
    logic next_trip_reg;
    logic rel_reg;
    logic next_rel_reg;
    logic armed;
    logic next_armed;

    always_comb
    begin
        next_tripped = tripped;
        next_trip_reg = trip_reg;
        next_rel_reg = rel_reg;
        next_armed = armed;
        if (meas.valid)
        begin
            next_trip_reg = in_trip;
            next_rel_reg = in_rel;
            if (in_rel)
                next_armed = 1'b1;
        end
        if (latching && clr_act && rel_reg)
            next_tripped = 1'b0;
        if (meas.valid)
        begin
            if (in_rel && !latching)
                next_tripped = 1'b0;
            if (in_trip && (armed || !inhibit))
                next_tripped = 1'b1;
        end
        if (ovr_act)
            next_tripped = 1'b0;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            tripped <= 1'b0;
            trip_reg <= 1'b0;
            rel_reg <= 1'b0;
            armed <= 1'b0;
        end
        else
        begin
            tripped <= next_tripped;
            trip_reg <= next_trip_reg;
            rel_reg <= next_rel_reg;
            armed <= next_armed;
        end
    end

    // =================================================================
    // Indicators and setting display
    logic [31:0] blink_cnt;
    logic [31:0] next_blink_cnt;
    logic [4:0] phase;
    logic [4:0] next_phase;
    logic [4:0] shown;
    logic next_relay;
    logic next_led_input;
    logic next_led_relay;

    always_comb
    begin
        case (cfg.item)
            2'h0: shown = {2'h0, cfg.mode} + 5'h01;
            2'h1: shown = {1'b0, cfg.win_sel} + 5'h01;
            2'h2: shown = {1'b0, cfg.off_sel} + 5'h01;
            default: shown = {1'b0, cfg.hyst_sel} + 5'h01;
        endcase
        next_blink_cnt = blink_cnt + 32'h0000_0001;
        next_phase = phase;
        if (!cfg.setup)
        begin
            next_blink_cnt = 32'h0000_0000;
            next_phase = 5'h00;
        end
        else if (blink_cnt + 32'h0000_0001 >= `FTS_BLINK_MS * 32'(TPM))
        begin
            next_blink_cnt = 32'h0000_0000;
            next_phase = phase + 5'h01;
            if (phase >= shown + 5'h04)
                next_phase = 5'h00;
        end
        next_relay = next_tripped;
        if (cfg.setup)
        begin
            next_led_input = phase < shown && !phase[0];
            next_led_relay = phase >= shown;
        end
        else
        begin
            next_led_input = ~pulse_sync[1];
            next_led_relay = next_tripped;
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            blink_cnt <= 32'h0000_0000;
            phase <= 5'h00;
            relay <= 1'b0;
            led_input <= 1'b0;
            led_relay <= 1'b0;
        end
        else
        begin
            blink_cnt <= next_blink_cnt;
            phase <= next_phase;
            relay <= next_relay;
            led_input <= next_led_input;
            led_relay <= next_led_relay;
        end
    end

    // =================================================================
    // Register read port
    logic [31:0] next_rdata;

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (!rd)
            next_rdata = 32'h0000_0000;
        else if (addr == `FTS_ADDR_CTRL)
            next_rdata = {14'h0000, cfg};
        else if (addr == `FTS_ADDR_TRIP)
            next_rdata = {14'h0000, trip};
        else if (addr == `FTS_ADDR_STATUS)
        begin
            next_rdata[`FTS_ST_RELAY] = tripped;
            next_rdata[`FTS_ST_TRIPREG] = trip_reg;
            next_rdata[`FTS_ST_RELREG] = rel_reg;
            next_rdata[`FTS_ST_OVR] = ovr_act;
            next_rdata[`FTS_ST_ARMED] = armed;
        end
        else if (addr == `FTS_ADDR_COUNT)
            next_rdata = {12'h000, meas.edges};
        else if (addr == `FTS_ADDR_TICKS)
            next_rdata = meas.ticks;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            rdata <= 32'h0000_0000;
        else
            rdata <= next_rdata;
    end

endmodule

/* dv/fts_sensor.sv */
`timescale 1ns/100ps

// ==========================================================
// Sensor model: one falling edge per period, idle high when stopped.
module fts_sensor
(
    // Clock
    input wire logic sys_clk,
    // Pulse period in clock cycles, zero stops the input
    input wire logic [15:0] period,
    // Sensor pin
    output logic pulse_in
);
    logic [15:0] cnt = 16'h0;

    always @(posedge sys_clk)
    begin
        if (period == 16'h0 || cnt >= period - 16'h1)
            cnt <= 16'h0;
        else
            cnt <= cnt + 16'h1;
    end

    assign pulse_in = (period == 16'h0) || (cnt < (period >> 1));
endmodule

/* dv/fts_monitor.sv */
`timescale 1ns/100ps
`include "fts_regs.svh"

// ==========================================================
// Checker of relay, indicators and read port.
module fts_monitor
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    // Pins
    input wire logic pulse_in,
    input wire logic override_n,
    input wire logic clear_n,
    input wire logic relay,
    input wire logic led_input,
    input wire logic led_relay
);
    logic setup;
    logic next_setup;
    logic [2:0] norm_cnt;
    logic [2:0] next_norm_cnt;

    // ==========================================================
    // Display mode tracking.
    always_comb
    begin
        next_setup = setup;
        if (wr && addr == `FTS_ADDR_CTRL)
            next_setup = wdata[15];
        next_norm_cnt = norm_cnt;
        if (setup)
            next_norm_cnt = 3'h0;
        else if (norm_cnt != 3'h7)
            next_norm_cnt = norm_cnt + 3'h1;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            setup <= 1'b0;
            norm_cnt <= 3'h0;
        end
        else
        begin
            setup <= next_setup;
            norm_cnt <= next_norm_cnt;
        end
    end

    // ==========================================================
    // Assertions.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_override_release: assert property (
        (!override_n) [*3] |=> !relay)
        else $error("relay not released under override");
    a_rise_cause: assert property (
        $rose(relay) |-> $past(override_n, 3))
        else $error("relay tripped while override active");
    a_rdata_idle: assert property (
        !rd |=> rdata == 32'h0)
        else $error("read data without a read");
    a_unmapped_read: assert property (
        rd && addr == 8'h14 |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property (
        $fell(reset) |-> !relay && !led_relay && rdata == 32'h0)
        else $error("outputs active after reset");
    a_led_relay_follow: assert property (
        norm_cnt == 3'h7 && $stable(relay) |-> led_relay == relay)
        else $error("relay indicator differs from relay");
    a_led_input_off: assert property (
        pulse_in [*5] ##0 norm_cnt == 3'h7 |-> !led_input)
        else $error("input indicator on with input high");
    a_led_input_on: assert property (
        (!pulse_in) [*5] ##0 norm_cnt == 3'h7 |-> led_input)
        else $error("input indicator off with input low");

    c_trip: cover property ($rose(relay));
    c_override: cover property (relay && !override_n);
    c_status: cover property (rd && addr == `FTS_ADDR_STATUS);
endmodule

bind fts_top fts_monitor fts_monitor_inst (.sys_clk(sys_clk),
    .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pulse_in(pulse_in), .override_n(override_n),
    .clear_n(clear_n), .relay(relay), .led_input(led_input),
    .led_relay(led_relay));

/* dv/tb_fts_top.sv */
`timescale 1ns/100ps
`include "fts_regs.svh"

// ==========================================================
// Bench for the speed switch, window counts scaled by CLK_HZ.
module tb_fts_top;
    logic sys_clk;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic pulse_in;
    logic override_n = 1'b1;
    logic clear_n = 1'b1;
    logic relay;
    logic led_input;
    logic led_relay;
    logic [15:0] period = 16'h0;
    logic [31:0] rv;
    logic [31:0] tk;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;

    fts_top #(.CLK_HZ(1000)) fts_top_inst (.sys_clk(sys_clk), .reset(reset),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .pulse_in(pulse_in), .override_n(override_n), .clear_n(clear_n),
        .relay(relay), .led_input(led_input), .led_relay(led_relay));
    fts_sensor fts_sensor_inst (.sys_clk(sys_clk), .period(period),
        .pulse_in(pulse_in));

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Access and check tasks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(negedge sys_clk);
        d = rdata;
        @(posedge sys_clk);
    endtask

    task automatic set_cfg(input fts_pkg::fts_mode_e m, input logic [3:0] o,
        input logic [3:0] h, input logic s);
        fts_pkg::fts_cfg_s c;
        c = '0;
        c.mode = m;
        c.win_sel = 4'h4;
        c.off_sel = o;
        c.hyst_sel = h;
        c.setup = s;
        c.item = 2'h1;
        wr_reg(`FTS_ADDR_CTRL, 32'(c));
    endtask

    task automatic wait_out(input logic led, input logic e, input int lim);
        int n;
        n = 0;
        @(negedge sys_clk);
        while ((led ? led_relay : relay) !== e && n < lim)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk({31'h0, (led ? led_relay : relay)}, {31'h0, e});
        @(posedge sys_clk);
    endtask

    task automatic hold(input int n, input logic e);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({31'h0, relay}, {31'h0, e});
        @(posedge sys_clk);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            error_cnt++;
            results();
        end
    end

    // ==========================================================
    // Test sequence.
    initial
    begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        rd_reg(`FTS_ADDR_CTRL, rv);
        chk(rv, 32'h0);
        rd_reg(`FTS_ADDR_TRIP, rv);
        chk(rv, 32'h0000_2710);
        rd_reg(8'h14, rv);
        chk(rv, 32'h0);
        wr_reg(`FTS_ADDR_TRIP, 32'h0);
        rd_reg(`FTS_ADDR_TRIP, rv);
        chk(rv, 32'h0000_0001);
        wr_reg(`FTS_ADDR_TRIP, 32'h0003_FFFF);
        rd_reg(`FTS_ADDR_TRIP, rv);
        chk(rv, 32'h0003_D090);
        wr_reg(`FTS_ADDR_CTRL, 32'h0000_7FFF);
        rd_reg(`FTS_ADDR_CTRL, rv);
        chk(rv, 32'h0000_4CC8);
        for (int m = 0; m < 6; m++)
        begin
            wr_reg(`FTS_ADDR_CTRL, 32'(m));
            rd_reg(`FTS_ADDR_CTRL, rv);
            chk(rv, 32'(m));
        end
        wr_reg(`FTS_ADDR_STATUS, 32'hFFFF_FFFF);
        rd_reg(`FTS_ADDR_STATUS, rv);
        chk(rv, 32'h0);
        $display("test registers done");
        wr_reg(`FTS_ADDR_TRIP, 32'd400);
        set_cfg(fts_pkg::FTS_OVER, 4'h0, 4'h0, 1'b0);
        period <= 16'd20;
        wait_out(1'b0, 1'b1, 600);
        rd_reg(`FTS_ADDR_COUNT, rv);
        rd_reg(`FTS_ADDR_TICKS, tk);
        chk(tk, rv * 32'd20);
        rd_reg(`FTS_ADDR_STATUS, rv);
        chk(rv & 32'h3, 32'h3);
        period <= 16'd40;
        wait_out(1'b0, 1'b0, 600);
        $display("test overspeed done");
        set_cfg(fts_pkg::FTS_OVER, 4'h0, 4'h9, 1'b0);
        period <= 16'd20;
        wait_out(1'b0, 1'b1, 600);
        period <= 16'd30;
        hold(400, 1'b1);
        period <= 16'd40;
        wait_out(1'b0, 1'b0, 600);
        set_cfg(fts_pkg::FTS_OVER, 4'h8, 4'h0, 1'b0);
        period <= 16'd22;
        hold(400, 1'b0);
        period <= 16'd20;
        wait_out(1'b0, 1'b1, 600);
        $display("test hysteresis and offset done");
        override_n <= 1'b0;
        wait_out(1'b0, 1'b0, 5);
        hold(300, 1'b0);
        override_n <= 1'b1;
        wait_out(1'b0, 1'b1, 600);
        $display("test override done");
        set_cfg(fts_pkg::FTS_OVER_LATCH, 4'h0, 4'h0, 1'b0);
        wait_out(1'b0, 1'b1, 600);
        clear_n <= 1'b0;
        hold(20, 1'b1);
        clear_n <= 1'b1;
        period <= 16'd40;
        hold(400, 1'b1);
        clear_n <= 1'b0;
        wait_out(1'b0, 1'b0, 10);
        clear_n <= 1'b1;
        $display("test latch done");
        set_cfg(fts_pkg::FTS_UNDER, 4'h0, 4'h0, 1'b0);
        period <= 16'd20;
        wait_out(1'b0, 1'b0, 600);
        period <= 16'd0;
        wait_out(1'b0, 1'b1, 10400);
        period <= 16'd20;
        wait_out(1'b0, 1'b0, 600);
        wr_reg(`FTS_ADDR_TRIP, 32'h0000_01F4);
        hold(300, 1'b0);
        wr_reg(`FTS_ADDR_TRIP, 32'h0000_01F5);
        wait_out(1'b0, 1'b1, 300);
        $display("test underspeed done");
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        wr_reg(`FTS_ADDR_TRIP, 32'h0000_0190);
        set_cfg(fts_pkg::FTS_UNDER_INH, 4'h0, 4'h0, 1'b0);
        period <= 16'h0028;
        hold(400, 1'b0);
        period <= 16'h0014;
        hold(300, 1'b0);
        period <= 16'h0028;
        wait_out(1'b0, 1'b1, 600);
        $display("test start inhibit done");
        set_cfg(fts_pkg::FTS_UNDER, 4'h0, 4'h0, 1'b1);
        wait_out(1'b1, 1'b1, 4000);
        set_cfg(fts_pkg::FTS_UNDER, 4'h0, 4'h0, 1'b0);
        $display("test setup display done");
        results();
    end
endmodule
